// ---- core/ioex_consts.svh ----
`ifndef IOEX_CONSTS_SVH
`define IOEX_CONSTS_SVH
// opcodes of the i/o instruction group
`define IOEX_OP_NOP 8'h00
`define IOEX_OP_IN_P0 8'h08
`define IOEX_OP_IN_P1 8'h09
`define IOEX_OP_IN_P2 8'h0A
`define IOEX_OP_RD_SDATA 8'h0C
`define IOEX_OP_RD_SSTAT 8'h0D
`define IOEX_OP_OUT_P0 8'h38
`define IOEX_OP_OUT_P1 8'h39
`define IOEX_OP_OUT_P2 8'h3A
`define IOEX_OP_WR_SDATA 8'h3C
`define IOEX_OP_WR_SCTRL 8'h3D
`define IOEX_OP_WR_SCLK 8'h3E
`define IOEX_OP_SI_EN 8'h85
`define IOEX_OP_OR_P0 8'h88
`define IOEX_OP_OR_P1 8'h89
`define IOEX_OP_OR_P2 8'h8A
`define IOEX_OP_EXT_RD 8'h8C
`define IOEX_OP_EXT_WR 8'h8D
`define IOEX_OP_EXT_AND 8'h8E
`define IOEX_OP_EXT_OR 8'h8F
`define IOEX_OP_SI_DIS 8'h95
`define IOEX_OP_AND_P0 8'h98
`define IOEX_OP_AND_P1 8'h99
`define IOEX_OP_AND_P2 8'h9A
`define IOEX_OP_IMM_SDATA 8'h9C
`define IOEX_OP_IMM_SCTRL 8'h9D
`define IOEX_OP_IMM_SCLK 8'h9E
// reset values and field layout
`define IOEX_PORT_RST 8'hFF
`define IOEX_ACC_RST 8'h00
`define IOEX_PC_RST 13'h0000
`define IOEX_PC_LOW_W 11
`define IOEX_P2_MASK 8'h0F
`endif

// ---- core/ioex_core.sv ----
`timescale 1ns/1ps
`include "ioex_consts.svh"
// What this block does
// - port input opcodes load accumulator, two cycles
// - port two read zeroes accumulator upper nibble
// - port output opcodes latch accumulator onto port
// - port and takes immediate byte, two cycles
// - port or takes immediate byte, two cycles
// - peripheral read loads addressed register into accumulator
// - peripheral write stores accumulator at direct address
// - peripheral and combines register with accumulator
// - peripheral or combines register with accumulator
// - serial data read copies shift register
// - serial status read differs from written control
// - accumulator writes serial data, control, clock registers
// - immediate byte writes serial data, control, clock
// - two opcodes set and clear serial irq enable
// - nop increments low eleven program counter bits
module ioex_core
  import ioex_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] code_byte,
  output logic code_fetch,
  output logic [12:0] pc_reg,
  output logic [7:0] acc_reg,
  input wire logic [7:0] port_zero_in,
  input wire logic [7:0] port_one_in,
  input wire logic [7:0] port_two_in,
  output logic [7:0] port_zero_reg,
  output logic [7:0] port_one_reg,
  output logic [7:0] port_two_reg,
  output logic [7:0] ext_addr_reg,
  output logic [7:0] ext_wdata_reg,
  output logic ext_rd_reg,
  output logic ext_wr_reg,
  input wire logic [7:0] ext_rdata,
  input wire logic [7:0] serial_data_shift_reg,
  input wire logic [7:0] serial_status_control_reg,
  output logic [7:0] serial_wdata_reg,
  output logic serial_wr_data_reg,
  output logic serial_wr_ctrl_reg,
  output logic serial_wr_clk_reg,
  output logic serial_irq_en_reg,
  output logic illegal_op_reg
);
  ioex_state_t state_reg;
  logic [7:0] op_reg;
  logic [7:0] p0_s1_reg, p0_s2_reg, p1_s1_reg, p1_s2_reg, p2_s1_reg, p2_s2_reg;
  logic one_byte;
  logic two_byte;
  logic known_op;

  // port pins come from outside: two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      p0_s1_reg <= 8'h00;
      p0_s2_reg <= 8'h00;
      p1_s1_reg <= 8'h00;
      p1_s2_reg <= 8'h00;
      p2_s1_reg <= 8'h00;
      p2_s2_reg <= 8'h00;
    end else begin
      p0_s1_reg <= port_zero_in;
      p0_s2_reg <= p0_s1_reg;
      p1_s1_reg <= port_one_in;
      p1_s2_reg <= p1_s1_reg;
      p2_s1_reg <= port_two_in;
      p2_s2_reg <= p2_s1_reg;
    end
  end

  // opcode classes; single-cycle ops never leave fetch
  always_comb begin
    one_byte = 1'b0;
    two_byte = 1'b0;
    case (code_byte)
      `IOEX_OP_IN_P0, `IOEX_OP_IN_P1, `IOEX_OP_IN_P2, `IOEX_OP_RD_SDATA,
      `IOEX_OP_RD_SSTAT, `IOEX_OP_OUT_P0, `IOEX_OP_OUT_P1, `IOEX_OP_OUT_P2,
      `IOEX_OP_WR_SDATA, `IOEX_OP_WR_SCTRL, `IOEX_OP_WR_SCLK: one_byte = 1'b1;
      `IOEX_OP_AND_P0, `IOEX_OP_AND_P1, `IOEX_OP_AND_P2, `IOEX_OP_OR_P0,
      `IOEX_OP_OR_P1, `IOEX_OP_OR_P2, `IOEX_OP_EXT_RD, `IOEX_OP_EXT_WR,
      `IOEX_OP_EXT_AND, `IOEX_OP_EXT_OR, `IOEX_OP_IMM_SDATA,
      `IOEX_OP_IMM_SCTRL, `IOEX_OP_IMM_SCLK: two_byte = 1'b1;
      default: one_byte = 1'b0;
    endcase
    known_op = one_byte | two_byte | (code_byte == `IOEX_OP_NOP) |
               (code_byte == `IOEX_OP_SI_EN) | (code_byte == `IOEX_OP_SI_DIS);
  end

  // a byte is consumed in fetch, and in exec2 for two-byte ops
  assign code_fetch = (state_reg == IOEX_FETCH) | ((state_reg == IOEX_EXEC2) &
                      (op_reg[7] == 1'b1));

  // sequencer: fetch, then a second cycle; ext and/or write back during the following fetch, IOEX_WB is never entered
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= IOEX_FETCH;
      op_reg <= 8'h00;
    end else begin
      case (state_reg)
        IOEX_FETCH: begin
          op_reg <= code_byte;
          if (one_byte | two_byte) begin
            state_reg <= IOEX_EXEC2;
          end
        end
        IOEX_EXEC2: state_reg <= IOEX_FETCH;
        default: state_reg <= IOEX_FETCH;
      endcase
    end
  end

  // program counter: low 11 bits wrap, bank bits untouched
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg <= `IOEX_PC_RST;
    end else if (code_fetch) begin
      pc_reg[`IOEX_PC_LOW_W-1:0] <= pc_reg[`IOEX_PC_LOW_W-1:0] + 11'h001;
    end
  end

  // unknown opcodes are flagged and skipped like a nop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      illegal_op_reg <= 1'b0;
    end else begin
      illegal_op_reg <= (state_reg == IOEX_FETCH) & ~known_op;
    end
  end

  // serial interrupt enable set/clear
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serial_irq_en_reg <= 1'b0;
    end else if (state_reg == IOEX_FETCH) begin
      if (code_byte == `IOEX_OP_SI_EN) begin
        serial_irq_en_reg <= 1'b1;
      end else if (code_byte == `IOEX_OP_SI_DIS) begin
        serial_irq_en_reg <= 1'b0;
      end
    end
  end

  // accumulator loads in the second cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= `IOEX_ACC_RST;
    end else if (state_reg == IOEX_EXEC2) begin
      case (op_reg)
        `IOEX_OP_IN_P0: acc_reg <= p0_s2_reg;
        `IOEX_OP_IN_P1: acc_reg <= p1_s2_reg;
        `IOEX_OP_IN_P2: acc_reg <= p2_s2_reg & `IOEX_P2_MASK;
        `IOEX_OP_RD_SDATA: acc_reg <= serial_data_shift_reg;
        // status view is a separate input from the written control fields
        `IOEX_OP_RD_SSTAT: acc_reg <= serial_status_control_reg;
        `IOEX_OP_EXT_RD: acc_reg <= ext_rdata;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  // port output latches; and/or act on the latch, not the pin
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port_zero_reg <= `IOEX_PORT_RST;
      port_one_reg <= `IOEX_PORT_RST;
      port_two_reg <= `IOEX_PORT_RST;
    end else if (state_reg == IOEX_EXEC2) begin
      case (op_reg)
        `IOEX_OP_OUT_P0: port_zero_reg <= acc_reg;
        `IOEX_OP_OUT_P1: port_one_reg <= acc_reg;
        `IOEX_OP_OUT_P2: port_two_reg <= acc_reg;
        `IOEX_OP_AND_P0: port_zero_reg <= port_zero_reg & code_byte;
        `IOEX_OP_AND_P1: port_one_reg <= port_one_reg & code_byte;
        `IOEX_OP_AND_P2: port_two_reg <= port_two_reg & code_byte;
        `IOEX_OP_OR_P0: port_zero_reg <= port_zero_reg | code_byte;
        `IOEX_OP_OR_P1: port_one_reg <= port_one_reg | code_byte;
        `IOEX_OP_OR_P2: port_two_reg <= port_two_reg | code_byte;
        default: port_zero_reg <= port_zero_reg;
      endcase
    end
  end

  // peripheral bus: address and read or write strobe in cycle 2, and/or write-back one cycle later
  // read data must be valid in exec2 for a plain read, and while ext_rd_reg is high for and/or (combinational answer)
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ext_addr_reg <= 8'h00;
      ext_rd_reg <= 1'b0;
      ext_wr_reg <= 1'b0;
      ext_wdata_reg <= 8'h00;
    end else begin
      ext_rd_reg <= 1'b0;
      ext_wr_reg <= 1'b0;
      // address holds through the write-back cycle of a read-modify-write
      if (state_reg == IOEX_EXEC2) begin
        case (op_reg)
          `IOEX_OP_EXT_RD: begin
            ext_addr_reg <= code_byte;
            ext_rd_reg <= 1'b1;
          end
          `IOEX_OP_EXT_WR: begin
            ext_addr_reg <= code_byte;
            ext_wdata_reg <= acc_reg;
            ext_wr_reg <= 1'b1;
          end
          `IOEX_OP_EXT_AND, `IOEX_OP_EXT_OR: begin
            ext_addr_reg <= code_byte;
            ext_rd_reg <= 1'b1;
          end
          default: ext_rd_reg <= 1'b0;
        endcase
      end
      // write-back of the combined value while the read is answered
      if (ext_rd_reg && (op_reg == `IOEX_OP_EXT_AND)) begin
        ext_wdata_reg <= ext_rdata & acc_reg;
        ext_wr_reg <= 1'b1;
      end else if (ext_rd_reg && (op_reg == `IOEX_OP_EXT_OR)) begin
        ext_wdata_reg <= ext_rdata | acc_reg;
        ext_wr_reg <= 1'b1;
      end
    end
  end

  // serial register writes: one pulse per instruction
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serial_wdata_reg <= 8'h00;
      serial_wr_data_reg <= 1'b0;
      serial_wr_ctrl_reg <= 1'b0;
      serial_wr_clk_reg <= 1'b0;
    end else begin
      serial_wr_data_reg <= 1'b0;
      serial_wr_ctrl_reg <= 1'b0;
      serial_wr_clk_reg <= 1'b0;
      if (state_reg == IOEX_EXEC2) begin
        serial_wdata_reg <= op_reg[7] ? code_byte : acc_reg;
        case (op_reg)
          `IOEX_OP_WR_SDATA, `IOEX_OP_IMM_SDATA: serial_wr_data_reg <= 1'b1;
          `IOEX_OP_WR_SCTRL, `IOEX_OP_IMM_SCTRL: serial_wr_ctrl_reg <= 1'b1;
          `IOEX_OP_WR_SCLK, `IOEX_OP_IMM_SCLK: serial_wr_clk_reg <= 1'b1;
          default: serial_wr_data_reg <= 1'b0;
        endcase
      end
    end
  end
endmodule // ioex_core

// ---- core/ioex_pkg.sv ----
package ioex_pkg;
  typedef enum logic [1:0] {IOEX_FETCH, IOEX_EXEC2, IOEX_WB} ioex_state_t;
  typedef enum logic [1:0] {IOEX_SEL_S0, IOEX_SEL_S1, IOEX_SEL_S2} ioex_sreg_t;
endpackage

// ---- tb/ioex_core_monitor.sv ----
`timescale 1ns/1ps
module ioex_core_monitor (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] code_byte,
  input wire logic code_fetch,
  input wire logic [12:0] pc_reg,
  input wire logic [7:0] acc_reg,
  input wire logic [7:0] port_zero_reg,
  input wire logic [7:0] ext_addr_reg,
  input wire logic [7:0] ext_wdata_reg,
  input wire logic ext_rd_reg,
  input wire logic ext_wr_reg,
  input wire logic serial_wr_data_reg,
  input wire logic serial_irq_en_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // second byte of a two-byte op is data and must not pass for an opcode
  logic imm_next;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      imm_next <= 1'b0;
    end else begin
      imm_next <= code_fetch & ~imm_next & (code_byte inside {8'h88, 8'h89, 8'h8A, 8'h8C,
                  8'h8D, 8'h8E, 8'h8F, 8'h98, 8'h99, 8'h9A, 8'h9C, 8'h9D, 8'h9E});
    end
  end
  // opcode being taken; zero when nothing is fetched
  logic [7:0] op;
  assign op = (code_fetch & ~imm_next) ? code_byte : 8'h00;
  a_pc_step: assert property (
    code_fetch |=> pc_reg[10:0] == $past(pc_reg[10:0]) + 11'h001)
    else $error("pc did not step by one");
  a_bank_hold: assert property ($stable(pc_reg[12:11]))
    else $error("pc bank bits moved");
  a_two_cycle: assert property (
    op inside {8'h08, 8'h38, 8'h0C} |=> !code_fetch ##1 code_fetch)
    else $error("single byte op not two cycles");
  a_p2_upper: assert property (op == 8'h0A |-> ##2 acc_reg[7:4] == 4'h0)
    else $error("port two read upper nibble set");
  a_port_out: assert property (op == 8'h38 |-> ##2 port_zero_reg == acc_reg)
    else $error("port zero latch not accumulator");
  a_ext_write: assert property (
    op == 8'h8D |-> ##2 ext_wr_reg && ext_wdata_reg == acc_reg)
    else $error("peripheral write strobe or data wrong");
  a_rmw_addr: assert property (ext_rd_reg ##1 ext_wr_reg |-> $stable(ext_addr_reg))
    else $error("write back went to another address");
  a_sdata_pulse: assert property (
    op == 8'h3C |-> ##2 serial_wr_data_reg ##1 !serial_wr_data_reg)
    else $error("serial data write pulse wrong");
  a_irq_cause: assert property (
    $changed(serial_irq_en_reg) |-> $past(op) == (serial_irq_en_reg ? 8'h85 : 8'h95))
    else $error("irq enable changed without its opcode");
endmodule // ioex_core_monitor

// ---- tb/ioex_core_test.sv ----
`timescale 1ns/1ps
module ioex_core_test;
  logic clk_sys = 1'b0;
  logic rst_b, code_fetch, ext_rd_reg, ext_wr_reg, serial_wr_data_reg;
  logic serial_wr_ctrl_reg, serial_wr_clk_reg, serial_irq_en_reg, illegal_op_reg;
  logic [12:0] pc_reg;
  logic [7:0] code_byte, acc_reg, port_zero_in, port_one_in, port_two_in, port_zero_reg;
  logic [7:0] port_one_reg, port_two_reg, ext_addr_reg, ext_wdata_reg, ext_rdata;
  logic [7:0] serial_data_shift_reg, serial_status_control_reg, serial_wdata_reg;
  logic [7:0] ctrl_seen_reg, clk_seen_reg;
  logic [7:0] prog [256];
  int err_count, n_checks, n_illegal;
  // program memory answers combinationally at the pc
  assign code_byte = prog[pc_reg[7:0]];
  ioex_core u_ioex_core (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .code_byte(code_byte),
    .code_fetch(code_fetch),
    .pc_reg(pc_reg),
    .acc_reg(acc_reg),
    .port_zero_in(port_zero_in),
    .port_one_in(port_one_in),
    .port_two_in(port_two_in),
    .port_zero_reg(port_zero_reg),
    .port_one_reg(port_one_reg),
    .port_two_reg(port_two_reg),
    .ext_addr_reg(ext_addr_reg),
    .ext_wdata_reg(ext_wdata_reg),
    .ext_rd_reg(ext_rd_reg),
    .ext_wr_reg(ext_wr_reg),
    .ext_rdata(ext_rdata),
    .serial_data_shift_reg(serial_data_shift_reg),
    .serial_status_control_reg(serial_status_control_reg),
    .serial_wdata_reg(serial_wdata_reg),
    .serial_wr_data_reg(serial_wr_data_reg),
    .serial_wr_ctrl_reg(serial_wr_ctrl_reg),
    .serial_wr_clk_reg(serial_wr_clk_reg),
    .serial_irq_en_reg(serial_irq_en_reg),
    .illegal_op_reg(illegal_op_reg)
  );
  ioex_periph_model u_ioex_periph_model (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .code_byte(code_byte),
    .ext_addr_reg(ext_addr_reg),
    .ext_wdata_reg(ext_wdata_reg),
    .ext_rd_reg(ext_rd_reg),
    .ext_wr_reg(ext_wr_reg),
    .ext_rdata(ext_rdata),
    .serial_wdata_reg(serial_wdata_reg),
    .serial_wr_data_reg(serial_wr_data_reg),
    .serial_wr_ctrl_reg(serial_wr_ctrl_reg),
    .serial_wr_clk_reg(serial_wr_clk_reg),
    .serial_data_shift_reg(serial_data_shift_reg),
    .serial_status_control_reg(serial_status_control_reg),
    .ctrl_seen_reg(ctrl_seen_reg),
    .clk_seen_reg(clk_seen_reg)
  );
  always #2.5 clk_sys = ~clk_sys;
  // count refused opcodes
  always @(posedge clk_sys) if (illegal_op_reg === 1'b1) n_illegal++;
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // reset, load, run; two leading nops let the pin synchronisers settle
  task automatic run(input logic [7:0] p [$]);
    rst_b = 1'b0;
    foreach (prog[i]) prog[i] = 8'h00;
    foreach (p[i]) prog[i + 2] = p[i];
    repeat (6) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    n_illegal = 0;
    repeat (40) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_ports();
    run('{8'h08, 8'h38, 8'h0A, 8'h39, 8'h09, 8'h3A});
    check(port_zero_reg, 8'h5A);
    check(port_one_reg, 8'h03);
    check(port_two_reg, 8'hA5);
  endtask
  task automatic t_port_logic();
    run('{8'h98, 8'h0F, 8'h88, 8'h30, 8'h99, 8'hF0, 8'h89, 8'h05, 8'h9A, 8'h6C, 8'h8A, 8'h01});
    check(port_zero_reg, 8'h3F);
    check(port_one_reg, 8'hF5);
    check(port_two_reg, 8'h6D);
  endtask
  // pattern at address a is a xor 5A before any write
  task automatic t_ext();
    run('{8'h08, 8'h8D, 8'h10, 8'h8C, 8'h21, 8'h8E, 8'h96, 8'h8F, 8'h55, 8'h38});
    check(u_ioex_periph_model.mem[8'h10], 8'h5A);
    check(port_zero_reg, 8'h7B);
    check(u_ioex_periph_model.mem[8'h96], 8'h48);
    check(u_ioex_periph_model.mem[8'h55], 8'h7F);
  endtask
  task automatic t_serial();
    run('{8'h08, 8'h3C, 8'h9C, 8'h66, 8'h3D, 8'h9D, 8'h44, 8'h3E, 8'h9E, 8'h21,
          8'h0C, 8'h38, 8'h0D});
    check(serial_data_shift_reg, 8'h66);
    check(ctrl_seen_reg, 8'h44);
    check(clk_seen_reg, 8'h21);
    check(port_zero_reg, 8'h66);
    check(acc_reg, 8'hBB);
  endtask
  // unknown opcode in the stream acts as a one-cycle nop
  task automatic t_irq_nop();
    run('{8'h85, 8'hFF});
    check({7'h00, serial_irq_en_reg}, 8'h01);
    check(8'(n_illegal), 8'h01);
    check(pc_reg[7:0], 8'h28);
    run('{8'h85, 8'h95});
    check({7'h00, serial_irq_en_reg}, 8'h00);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence; pin values fixed for every scenario
  initial begin
    rst_b = 1'b0;
    port_zero_in = 8'h5A;
    port_one_in = 8'hA5;
    port_two_in = 8'hC3;
    t_ports();
    t_port_logic();
    t_ext();
    t_serial();
    t_irq_nop();
    wrap_up();
  end
  // six runs of under fifty cycles each
  initial begin
    #4000;
    err_count++;
    wrap_up();
  end
endmodule // ioex_core_test
bind ioex_core ioex_core_monitor u_mon (.clk_sys(clk_sys), .rst_b(rst_b),
  .code_byte(code_byte), .code_fetch(code_fetch), .pc_reg(pc_reg), .acc_reg(acc_reg),
  .port_zero_reg(port_zero_reg), .ext_addr_reg(ext_addr_reg), .ext_wdata_reg(ext_wdata_reg),
  .ext_rd_reg(ext_rd_reg), .ext_wr_reg(ext_wr_reg), .serial_wr_data_reg(serial_wr_data_reg),
  .serial_irq_en_reg(serial_irq_en_reg));

// ---- tb/ioex_periph_model.sv ----
`timescale 1ns/1ps
module ioex_periph_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] code_byte,
  input wire logic [7:0] ext_addr_reg,
  input wire logic [7:0] ext_wdata_reg,
  input wire logic ext_rd_reg,
  input wire logic ext_wr_reg,
  output logic [7:0] ext_rdata,
  input wire logic [7:0] serial_wdata_reg,
  input wire logic serial_wr_data_reg,
  input wire logic serial_wr_ctrl_reg,
  input wire logic serial_wr_clk_reg,
  output logic [7:0] serial_data_shift_reg,
  output logic [7:0] serial_status_control_reg,
  output logic [7:0] ctrl_seen_reg,
  output logic [7:0] clk_seen_reg
);
  logic [7:0] mem [256];
  // answers inside the strobe cycle; else follows the address byte on the code bus
  assign ext_rdata = mem[ext_rd_reg ? ext_addr_reg : code_byte];
  // read view deliberately differs from the written control
  assign serial_status_control_reg = ~ctrl_seen_reg;
  // register space, reset to an address-derived pattern
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= 8'(i) ^ 8'h5A;
      end
    end else if (ext_wr_reg) begin
      mem[ext_addr_reg] <= ext_wdata_reg;
    end
  end
  // serial interface registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      serial_data_shift_reg <= 8'h00;
      ctrl_seen_reg <= 8'h00;
      clk_seen_reg <= 8'h00;
    end else begin
      if (serial_wr_data_reg) serial_data_shift_reg <= serial_wdata_reg;
      if (serial_wr_ctrl_reg) ctrl_seen_reg <= serial_wdata_reg;
      if (serial_wr_clk_reg) clk_seen_reg <= serial_wdata_reg;
    end
  end
endmodule // ioex_periph_model
